// ==== core/brcf_top.sv ====
`timescale 1ns/1ps
module brcf_top
   import brcf_pkg::*;
#(
   parameter logic [15:0] OSC_DIV    = OSC_DIV_DEF,
   parameter logic [10:0] SS_PERIODS = SS_PERIODS_DEF,
   parameter logic [12:0] HICCUP_LEN = HICCUP_DEF,
   parameter logic [10:0] PG_RISE    = PG_RISE_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire brcf_cmp_s   cmp_i,
   output logic             hs_drive_o,
   output logic             ls_drive_o,
   output logic             en_pd_strong_o,
   output logic             pg_o,
   output logic             pg_oe_o,
   output logic [10:0]      ss_ramp_o,
   output brcf_tgt_e        target_sel_o,
   output logic             irq_o,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ==========================================================
   // declarations
   // ==========================================================
   brcf_cmp_s   s1_q, s2_q;
   brcf_state_e state_q, state_d;
   brcf_tgt_e   tgt_q, tgt_d;
   logic [15:0] osc_cnt_q;
   logic [10:0] ramp_q, ramp_d;
   logic [12:0] hic_cnt_q;
   logic [10:0] pg_cnt_q;
   logic [3:0]  oc_cnt_q;
   logic [1:0]  fold_cnt_q;
   logic        en_q, en_d;
   logic        supply_ok_q, supply_ok_d;
   logic        ovp_q, ovp_d;
   logic        prebias_q, prebias_d;
   logic        pg_q, pg_d;
   logic        hs_on_q, hs_on_d;
   logic        ls_on_q, ls_on_d;
   logic        otp_prev_q;
   logic [0:0]  ctrl_q;
   logic [7:0]  irq_stat_q, irq_mask_q;
   logic [7:0]  ev;
   logic        tick, active, fold_ok, period_start, run_ok;
   logic        oc_hit, peak_limit_set_pin_event, hic_enter, enter_soft, in_win;
   logic        pg_flip, blank;

   // ==========================================================
   // comparator synchronisers
   // ==========================================================
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (ce) begin
         s1_q <= cmp_i;
         s2_q <= s1_q;
      end
   end

   // ==========================================================
   // oscillator and hysteresis latches
   // ==========================================================
   assign tick        = (osc_cnt_q == OSC_DIV - 16'h0001);
   assign en_d        = s2_q.en_above_rise ? 1'b1 :
                        (s2_q.en_below_fall ? 1'b0 : en_q);
   assign supply_ok_d = s2_q.supply_above_high ? 1'b1 :
                        (s2_q.supply_below_low ? 1'b0 : supply_ok_q);
   assign ovp_d       = s2_q.fb_ge_0p7 ? 1'b1 :
                        (s2_q.fb_le_0p63 ? 1'b0 : ovp_q);
   assign run_ok      = en_q & ctrl_q[0] & supply_ok_q & ~s2_q.over_temp;
   assign en_pd_strong_o = ~en_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osc_cnt_q   <= 16'h0000;
         en_q        <= 1'b0;
         supply_ok_q <= 1'b0;
         ovp_q       <= 1'b0;
         otp_prev_q  <= 1'b0;
      end else if (ce) begin
         osc_cnt_q   <= tick ? 16'h0000 : osc_cnt_q + 16'h0001;
         en_q        <= en_d;
         supply_ok_q <= supply_ok_d;
         ovp_q       <= ovp_d;
         otp_prev_q  <= s2_q.over_temp;
      end
   end

   // ==========================================================
   // sequencer
   // ==========================================================
   assign oc_hit     = (oc_cnt_q == OC_LIMIT);
   assign active     = (state_q == ST_SOFT) | (state_q == ST_RUN);
   assign hic_enter  = (state_d == ST_HICCUP) & (state_q != ST_HICCUP);
   assign enter_soft = (state_d == ST_SOFT) & (state_q != ST_SOFT);

   always_comb begin
      state_d = state_q;
      if (!run_ok) begin
         state_d = ST_OFF;
      end else begin
         case (state_q)
            ST_OFF: begin
               state_d = ST_SOFT;
            end
            ST_SOFT: begin
               if (oc_hit) begin
                  state_d = ST_HICCUP;
               end else if (ramp_q == SS_PERIODS) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (oc_hit || !s2_q.fb_ge_0p4) begin
                  state_d = ST_HICCUP;
               end
            end
            ST_HICCUP: begin
               if (tick && hic_cnt_q == HICCUP_LEN - 13'h0001) begin
                  state_d = ST_SOFT;
               end
            end
            default: begin
               state_d = ST_OFF;
            end
         endcase
      end
   end

   always_comb begin
      ramp_d = ramp_q;
      if (state_d != ST_SOFT && state_d != ST_RUN) begin
         ramp_d = 11'h000;
      end else if (enter_soft) begin
         ramp_d = 11'h000;
      end else if (state_q == ST_SOFT && tick && ramp_q != SS_PERIODS) begin
         ramp_d = ramp_q + 11'h001;
      end
   end

   // lowest of reference, internal ramp and external pin
   assign tgt_d = s2_q.sspin_below_ramp ? TGT_PIN :
                  ((ramp_d != SS_PERIODS) ? TGT_RAMP : TGT_REF);

   assign prebias_d = enter_soft ? 1'b1 : (s2_q.ss_above_fb ? 1'b0 : prebias_q);

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q   <= ST_OFF;
         ramp_q    <= 11'h000;
         tgt_q     <= TGT_REF;
         prebias_q <= 1'b0;
         hic_cnt_q <= 13'h0000;
         oc_cnt_q  <= 4'h0;
      end else if (ce) begin
         state_q   <= state_d;
         ramp_q    <= ramp_d;
         tgt_q     <= tgt_d;
         prebias_q <= prebias_d;
         if (state_q != ST_HICCUP || state_d != ST_HICCUP) begin
            hic_cnt_q <= 13'h0000;
         end else if (tick) begin
            hic_cnt_q <= hic_cnt_q + 13'h0001;
         end
         if (state_d == ST_OFF || state_d == ST_HICCUP) begin
            oc_cnt_q <= 4'h0;
         end else if (peak_limit_set_pin_event && !oc_hit) begin
            oc_cnt_q <= oc_cnt_q + 4'h1;
         end
      end
   end

   assign ss_ramp_o    = ramp_q;
   assign target_sel_o = tgt_q;

   // ==========================================================
   // switch control with foldback
   // ==========================================================
   assign fold_ok = (state_q != ST_SOFT) | s2_q.fb_ge_0p4 |
                    (s2_q.fb_ge_0p2 ? ~fold_cnt_q[0] : (fold_cnt_q == 2'h0));
   // a start that coincides with blanking is dropped, blanking wins
   assign period_start = tick & active & fold_ok & ~blank;
   assign blank        = ovp_d | ((state_d != ST_SOFT) & (state_d != ST_RUN));
   assign peak_limit_set_pin_event   = hs_on_q & s2_q.peak_limit_set_pin_trip;

   always_comb begin
      hs_on_d = hs_on_q;
      ls_on_d = ls_on_q;
      if (blank) begin
         hs_on_d = 1'b0;
         ls_on_d = 1'b0;
      end else if (period_start) begin
         hs_on_d = 1'b1;
         ls_on_d = 1'b0;
      end else if (hs_on_q && (s2_q.peak_trip || s2_q.peak_limit_set_pin_trip)) begin
         hs_on_d = 1'b0;
         ls_on_d = 1'b1;
      end else if (ls_on_q && s2_q.sink_trip) begin
         ls_on_d = 1'b0;
      end
      if (prebias_d) begin
         ls_on_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hs_on_q    <= 1'b0;
         ls_on_q    <= 1'b0;
         fold_cnt_q <= 2'h0;
      end else if (ce) begin
         hs_on_q <= hs_on_d;
         ls_on_q <= ls_on_d;
         if (state_q != ST_SOFT) begin
            fold_cnt_q <= 2'h0;
         end else if (tick) begin
            fold_cnt_q <= fold_cnt_q + 2'h1;
         end
      end
   end

   assign hs_drive_o = hs_on_q;
   assign ls_drive_o = ls_on_q;

   // ==========================================================
   // regulation flag with deglitch
   // ==========================================================
   assign in_win  = ~s2_q.fb_over_win & ~s2_q.fb_under_win;
   assign pg_flip = (in_win != pg_q) & tick &
                    (pg_cnt_q == (pg_q ? PG_FALL : PG_RISE) - 11'h001);
   assign pg_d    = pg_flip ? ~pg_q : pg_q;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pg_q     <= 1'b0;
         pg_cnt_q <= 11'h000;
      end else if (ce) begin
         pg_q <= pg_d;
         if (in_win == pg_q || pg_flip) begin
            pg_cnt_q <= 11'h000;
         end else if (tick) begin
            pg_cnt_q <= pg_cnt_q + 11'h001;
         end
      end
   end

   assign pg_o    = 1'b0;
   assign pg_oe_o = ~pg_q;

   // ==========================================================
   // interrupts
   // ==========================================================
   assign ev[EV_OCP]    = peak_limit_set_pin_event;
   assign ev[EV_HICCUP] = hic_enter;
   assign ev[EV_OVP]    = ovp_d & ~ovp_q;
   assign ev[EV_SINK]   = ls_on_q & s2_q.sink_trip;
   assign ev[EV_PG_UP]  = pg_d & ~pg_q;
   assign ev[EV_PG_DN]  = ~pg_d & pg_q;
   assign ev[EV_UVLO]   = supply_ok_q & ~supply_ok_d;
   assign ev[EV_OTP]    = s2_q.over_temp & ~otp_prev_q;
   assign irq_o         = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // axi4-lite slave
   // ==========================================================
   logic        aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic        do_wr, wr_ctrl, wr_stat, wr_mask, wr_hit, rd_hit;
   logic [7:0]  stat_clr;
   logic [31:0] status_word, rd_word;

   assign s_axi_awready = ~aw_q & ~bvalid_q;
   assign s_axi_wready  = ~w_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign do_wr    = aw_q & w_q & ~bvalid_q;
   assign wr_ctrl  = do_wr & (awaddr_q == ADDR_CTRL) & wstrb_q[0];
   assign wr_stat  = do_wr & (awaddr_q == ADDR_IRQ_STAT) & wstrb_q[0];
   assign wr_mask  = do_wr & (awaddr_q == ADDR_IRQ_MASK) & wstrb_q[0];
   assign wr_hit   = (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_STATUS) |
                     (awaddr_q == ADDR_IRQ_STAT) | (awaddr_q == ADDR_IRQ_MASK) |
                     (awaddr_q == ADDR_RAMP);
   assign stat_clr = wr_stat ? wdata_q[7:0] : 8'h00;

   assign status_word = {18'h00000, s2_q.pg_pin, oc_cnt_q, ls_on_q, hs_on_q, pg_q,
                         ovp_q, prebias_q, supply_ok_q, en_q, state_q};
   assign rd_hit  = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_STATUS) |
                    (s_axi_araddr == ADDR_IRQ_STAT) | (s_axi_araddr == ADDR_IRQ_MASK) |
                    (s_axi_araddr == ADDR_RAMP);
   assign rd_word = (s_axi_araddr == ADDR_CTRL)     ? {31'h00000000, ctrl_q} :
                    (s_axi_araddr == ADDR_STATUS)   ? status_word :
                    (s_axi_araddr == ADDR_IRQ_STAT) ? {24'h000000, irq_stat_q} :
                    (s_axi_araddr == ADDR_IRQ_MASK) ? {24'h000000, irq_mask_q} :
                    (s_axi_araddr == ADDR_RAMP)     ? {21'h000000, ramp_q} :
                    32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_DECERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_q     <= CTRL_RST;
         irq_mask_q <= IRQ_MASK_RST;
         irq_stat_q <= 8'h00;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_q[0:0];
         end
         if (wr_mask) begin
            irq_mask_q <= wdata_q[7:0];
         end
         // a new event wins over a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~stat_clr) | ev;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst || !ce);

   sequence seq_hic_exit;
      (state_q == ST_HICCUP) ##1 (state_q == ST_SOFT);
   endsequence

   start_hs_on_a: assert property (period_start |=> hs_on_q && !ls_on_q)
      else $error("high side not on at period start");
   peak_off_a: assert property (hs_on_q && s2_q.peak_trip && !period_start |=> !hs_on_q)
      else $error("high side still on after peak trip");
   en_fall_a: assert property ($fell(en_q) |-> $past(s2_q.en_below_fall))
      else $error("enable dropped without falling threshold");
   ss_len_a: assert property ((state_q == ST_SOFT) ##1 (state_q == ST_RUN)
                              |-> $past(ramp_q) == SS_PERIODS)
      else $error("soft start ended early");
   prebias_ls_a: assert property (prebias_q |-> !ls_on_q)
      else $error("low side on during precharge protection");
   pg_rise_a: assert property ($rose(pg_q) |-> $past(pg_cnt_q) == PG_RISE - 11'h001
                               && $past(in_win))
      else $error("flag rose without full deglitch");
   hic_off_a: assert property (state_q == ST_HICCUP |-> !hs_on_q && !ls_on_q)
      else $error("switch on during hiccup");
   oc_hic_a: assert property (oc_hit && state_q == ST_RUN && run_ok
                              |=> state_q == ST_HICCUP)
      else $error("no hiccup at overcurrent count");
   hic_len_a: assert property (seq_hic_exit
                               |-> $past(hic_cnt_q) == HICCUP_LEN - 13'h0001)
      else $error("hiccup ended at wrong count");
   sink_off_a: assert property (ls_on_q && s2_q.sink_trip && !period_start
                                |=> !ls_on_q && !hs_on_q)
      else $error("low side still on after sink trip");
   ovp_off_a: assert property (ovp_q |-> !hs_on_q && !ls_on_q)
      else $error("switch on during overvoltage");
   uvlo_off_a: assert property (!supply_ok_q |=> state_q == ST_OFF)
      else $error("not off during lockout");

endmodule

// ==== core/brcf_pkg.sv ====
package brcf_pkg;

   // ==========================================================
   // clocking and oscillator
   // ==========================================================
   localparam int          SYS_CLK_KHZ     = 200000;
   localparam int          OSC_FREQ_KHZ    = 600;
   localparam logic [15:0] OSC_DIV_DEF     = 16'(SYS_CLK_KHZ / OSC_FREQ_KHZ);

   // ==========================================================
   // sequencing counts, in oscillator periods; overcurrent limit in trip events
   // ==========================================================
   localparam logic [10:0] SS_PERIODS_DEF  = 11'd1600;
   localparam logic [12:0] HICCUP_DEF      = 13'd4096;
   localparam logic [10:0] PG_RISE_DEF     = 11'd1024;
   localparam logic [10:0] PG_FALL         = 11'd16;
   localparam logic [3:0]  OC_LIMIT        = 4'd10;

   // ==========================================================
   // register map and reset values
   // ==========================================================
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_STATUS     = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h0c;
   localparam logic [7:0]  ADDR_RAMP       = 8'h10;
   localparam logic [0:0]  CTRL_RST        = 1'h1;
   localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;

   // ==========================================================
   // interrupt event bits
   // ==========================================================
   localparam int EV_OCP    = 0;
   localparam int EV_HICCUP = 1;
   localparam int EV_OVP    = 2;
   localparam int EV_SINK   = 3;
   localparam int EV_PG_UP  = 4;
   localparam int EV_PG_DN  = 5;
   localparam int EV_UVLO   = 6;
   localparam int EV_OTP    = 7;

   // ==========================================================
   // types
   // ==========================================================
   typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP} brcf_state_e;
   typedef enum logic [1:0] {TGT_REF, TGT_RAMP, TGT_PIN} brcf_tgt_e;

   typedef struct packed {
      logic peak_trip;
      logic peak_limit_set_pin_trip;
      logic sink_trip;
      logic en_above_rise;
      logic en_below_fall;
      logic supply_above_high;
      logic supply_below_low;
      logic over_temp;
      logic fb_ge_0p4;
      logic fb_ge_0p2;
      logic fb_ge_0p7;
      logic fb_le_0p63;
      logic fb_over_win;
      logic fb_under_win;
      logic ss_above_fb;
      logic sspin_below_ramp;
      logic pg_pin;
   } brcf_cmp_s;

endpackage

// ==== verification/brcf_plant.sv ====
`timescale 1ns/1ps
module brcf_plant
   import brcf_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       hs,
   input  wire logic       ls,
   input  wire logic       pg_oe,
   input  wire logic [1:0] fb_lvl,
   input  wire logic       en_hi,
   input  wire logic       hard_load,
   output brcf_cmp_s       cmp
);
   // ==========================================================
   // inductor current in steps: rises with high side, falls with low side
   // ==========================================================
   logic [3:0] cur_q = 4'h0;
   always_ff @(posedge sys_clk) begin
      if (hs && !cur_q[3]) begin
         cur_q <= cur_q + 4'h1;
      end else if (ls && cur_q != 4'h0) begin
         cur_q <= cur_q - 4'h1;
      end
   end
   // fb_lvl: 0 below 0.2, 1 below 0.4, 2 in window, 3 overvoltage
   // the flag line is pulled up, so it reads high once released
   // hard_load: current limit trips with the peak, sink limit trips once current runs out
   assign cmp = {cur_q >= 4'h3, (hard_load ? cur_q >= 4'h3 : cur_q >= 4'h6),
                 hard_load & ls & (cur_q == 4'h0), en_hi, !en_hi, 1'b1, 1'b0, 1'b0,
                 fb_lvl[1], fb_lvl != 2'h0, fb_lvl == 2'h3, fb_lvl != 2'h3,
                 fb_lvl == 2'h3, !fb_lvl[1], 1'b1, 1'b0, !pg_oe};
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
   import brcf_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        nrst, ce, en_hi, hs_drive_o, ls_drive_o, en_pd_strong_o, pg_o, pg_oe_o, irq_o;
   logic [1:0]  fb_lvl, s_axi_bresp, s_axi_rresp;
   logic [10:0] ss_ramp_o;
   brcf_cmp_s   cmp;
   brcf_tgt_e   target_sel_o;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        hard_load;
   logic [65:0] exp_q[$];
   logic [15:0] rnd;
   int          n_fail = 0, comparisons = 0, cyc = 0;

   always #2.5 sys_clk = ~sys_clk;

   brcf_top #(.OSC_DIV(16'h0010), .SS_PERIODS(11'h008), .HICCUP_LEN(13'h0008),
              .PG_RISE(11'h014)) i_brcf_top (.sys_clk, .nrst, .ce, .cmp_i(cmp), .hs_drive_o,
      .ls_drive_o, .en_pd_strong_o, .pg_o, .pg_oe_o, .ss_ramp_o, .target_sel_o, .irq_o,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   brcf_plant i_brcf_plant (.sys_clk, .hs(hs_drive_o), .ls(ls_drive_o), .pg_oe(pg_oe_o),
      .fb_lvl, .en_hi, .hard_load, .cmp);

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   // the expected word is noted here and judged by the read monitor
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] r);
      @(posedge sys_clk);
      exp_q.push_back({r, m, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
   endtask

   always @(posedge sys_clk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk("rdata", exp_q[0][31:0], s_axi_rdata & exp_q[0][63:32]);
         chk("rresp", {30'h0, exp_q[0][65:64]}, {30'h0, s_axi_rresp});
         void'(exp_q.pop_front());
      end
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   initial begin
      {nrst, en_hi, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {hard_load, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_rready = 1'b1;
      {ce, fb_lvl, s_axi_wstrb, rnd} = {1'b1, 2'h2, 4'hf, lfsr(16'h1cc2)};
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      axi_rd(ADDR_STATUS, 32'h3, 32'h0, RESP_OKAY);
      axi_rd(8'h14, 32'hffffffff, 32'h0, RESP_DECERR);
      chk("en_pd_strong_o", 32'h1, {31'h0, en_pd_strong_o});
      en_hi <= 1'b1;
      wait (ss_ramp_o == 11'h008);
      repeat (4) @(posedge sys_clk);
      axi_rd(ADDR_STATUS, 32'h3, 32'h2, RESP_OKAY);
      chk("en_pd_strong_o", 32'h0, {31'h0, en_pd_strong_o});
      chk("target_sel_o", {30'h0, TGT_REF}, {30'h0, target_sel_o});
      wait (hs_drive_o);
      wait (!hs_drive_o);
      @(negedge sys_clk);
      chk("ls_drive_o", 32'h1, {31'h0, ls_drive_o});
      for (int n = 0; n < 20 && !hs_drive_o; n++) @(negedge sys_clk);
      chk("hs_drive_o", 32'h1, {31'h0, hs_drive_o});
      axi_wr(ADDR_IRQ_MASK, {16'h0, rnd});
      axi_rd(ADDR_IRQ_MASK, 32'hff, {24'h0, rnd[7:0]}, RESP_OKAY);
      axi_wr(ADDR_IRQ_MASK, 32'h4);
      fb_lvl <= 2'h3;
      repeat (8) @(negedge sys_clk);
      chk("switches", 32'h0, {30'h0, hs_drive_o, ls_drive_o});
      chk("irq_o", 32'h1, {31'h0, irq_o});
      axi_rd(ADDR_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
      fb_lvl <= 2'h2;
      axi_wr(ADDR_IRQ_STAT, 32'h4);
      axi_rd(ADDR_IRQ_STAT, 32'h4, 32'h0, RESP_OKAY);
      chk("irq_o", 32'h0, {31'h0, irq_o});
      wait (hs_drive_o);
      fb_lvl <= 2'h0;
      repeat (8) @(negedge sys_clk);
      chk("switches", 32'h0, {30'h0, hs_drive_o, ls_drive_o});
      axi_rd(ADDR_STATUS, 32'h3, 32'h3, RESP_OKAY);
      repeat (140) @(posedge sys_clk);
      axi_rd(ADDR_STATUS, 32'h3, 32'h1, RESP_OKAY);
      chk("target_sel_o", {30'h0, TGT_RAMP}, {30'h0, target_sel_o});
      // heavy load: every period hits the current limit and the sink limit
      fb_lvl <= 2'h2;
      hard_load <= 1'b1;
      axi_wr(ADDR_IRQ_STAT, 32'hff);
      repeat (400) @(posedge sys_clk);
      axi_rd(ADDR_IRQ_STAT, 32'hb, 32'hb, RESP_OKAY);
      chk("pg_oe_o", 32'h0, {31'h0, pg_oe_o});
      chk("pg_o", 32'h0, {31'h0, pg_o});
      en_hi <= 1'b0;
      repeat (8) @(posedge sys_clk);
      axi_rd(ADDR_STATUS, 32'h3, 32'h0, RESP_OKAY);
      chk("en_pd_strong_o", 32'h1, {31'h0, en_pd_strong_o});
      fb_lvl <= 2'h0;
      repeat (300) @(negedge sys_clk);
      chk("pg_oe_o", 32'h1, {31'h0, pg_oe_o});
      report_and_stop();
   end
endmodule
